// *** src/swm_pkg.sv ***
package swm_pkg;

   // ==========================================================
   // data path geometry
   localparam int SWM_DATA_W    = 36;
   localparam int SWM_BMASK_W   = 4;
   localparam int SWM_NMASK_W   = 2;
   localparam int SWM_LANE_W    = 9;
   localparam int SWM_NIB_W     = 4;
   localparam int SWM_BURST_LEN = 4;
   localparam int SWM_BEAT_W    = 2;
   localparam int SWM_ADDR_W    = 8;

   // ==========================================================
   // data width configurations
   localparam int SWM_CFG_X8  = 8;
   localparam int SWM_CFG_X9  = 9;
   localparam int SWM_CFG_X18 = 18;
   localparam int SWM_CFG_X36 = 36;

   // ==========================================================
   // reset values and counts
   localparam logic [1:0]            SWM_BEAT_RST   = 2'h0;
   localparam logic [1:0]            SWM_BEAT_LAST  = 2'h3;
   localparam logic [1:0]            SWM_STRAP_WAIT = 2'h2;
   localparam logic [1:0]            SWM_CNT_FULL   = 2'h2;
   localparam logic [SWM_DATA_W-1:0] SWM_DATA_RST   = 36'h0;

   // ==========================================================
   // last operation started on a true-clock edge
   typedef enum logic [1:0] {
      SWM_LAST_NONE,
      SWM_LAST_READ,
      SWM_LAST_WRITE
   } swm_last_type;

endpackage

// *** src/swm_sram_write_mask.sv ***
`timescale 1ns/1ps

// Contract
// - x8 with both nibble masks low writes all eight bits of the beat.
// - x8 mask0 low, mask1 high writes bits 3:0, keeps bits 7:4.
// - x8 mask0 high, mask1 low writes bits 7:4, keeps bits 3:0.
// - x18 mask0 governs bits 8:0, mask1 bits 17:9; high keeps.
// - x9 single mask low writes bits 8:0, high writes nothing.
// - x36 all four masks low writes all 36 bits.
// - x36 masks 0..3 each enable one 9-bit lane; high lanes unaltered.
// - every mask high on a beat leaves the array untouched.
// - data and masks sampled on every true and complementary clock edge.
// - masks may change per beat; each beat uses its own masks.
// - read data paced by output clock, or input clock in single mode.
// - after reset deselected with read outputs tristated.
// - second read or write on consecutive true edges is ignored.
// - a select taken last true edge is don't-care on the next.
// - burst touches A, A+1, A+2, A+3 over following cycles.
// - write starts on low select; beats begin at the next true edge.
module swm_sram_write_mask
   import swm_pkg::*;
#(
   parameter int CFG_WIDTH = SWM_CFG_X18,
   parameter int ADDR_W    = SWM_ADDR_W
) (
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  true_clk_edge_in,
   input  wire logic                  out_clk_edge_in,
   input  wire logic                  out_clk_true_pin_in,
   input  wire logic                  out_clk_comp_pin_in,
   input  wire logic                  read_port_select_n_in,
   input  wire logic                  write_port_select_n_in,
   input  wire logic [ADDR_W-1:0]     addr_in,
   input  wire logic [SWM_DATA_W-1:0] wr_data_in,
   input  wire logic                  byte_lane_mask_0_n_in,
   input  wire logic                  byte_lane_mask_1_n_in,
   input  wire logic                  byte_lane_mask_2_n_in,
   input  wire logic                  byte_lane_mask_3_n_in,
   input  wire logic                  nibble_lane_mask_0_n_in,
   input  wire logic                  nibble_lane_mask_1_n_in,
   input  wire logic                  rd_ready_in,
   output logic [SWM_DATA_W-1:0]      rd_data_out,
   output logic                       rd_data_oe_out,
   output logic                       rd_valid_out,
   output logic                       single_clock_mode_out
);

   // ==========================================================
   // lane decode
   function automatic logic [SWM_DATA_W-1:0] swm_bit_enable(
      input logic [SWM_BMASK_W-1:0] bmask_n,
      input logic [SWM_NMASK_W-1:0] nmask_n
   );
      logic [SWM_DATA_W-1:0] en;
      en = '0;
      case (CFG_WIDTH)
         SWM_CFG_X8: begin
            en[SWM_NIB_W-1:0]           = {SWM_NIB_W{~nmask_n[0]}};
            en[2*SWM_NIB_W-1:SWM_NIB_W] = {SWM_NIB_W{~nmask_n[1]}};
         end
         SWM_CFG_X9: begin
            en[SWM_LANE_W-1:0] = {SWM_LANE_W{~bmask_n[0]}};
         end
         SWM_CFG_X18: begin
            for (int i = 0; i < 2; i++) begin
               en[i*SWM_LANE_W +: SWM_LANE_W] = {SWM_LANE_W{~bmask_n[i]}};
            end
         end
         default: begin
            for (int i = 0; i < SWM_BMASK_W; i++) begin
               en[i*SWM_LANE_W +: SWM_LANE_W] = {SWM_LANE_W{~bmask_n[i]}};
            end
         end
      endcase
      return en;
   endfunction

   // ==========================================================
   // declarations
   logic [SWM_DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [1:0]            strap_t_reg;
   logic [1:0]            strap_c_reg;
   logic [1:0]            strap_wait_reg;
   logic                  strap_done_reg;
   logic                  single_mode_reg;
   swm_last_type          last_op_reg;
   logic                  rd_take;
   logic                  wr_take;
   logic                  warm_reg;
   logic [ADDR_W-1:0]     warm_addr_reg;
   logic                  wact_reg;
   logic [ADDR_W-1:0]     wbase_reg;
   logic [SWM_BEAT_W-1:0] wbeat_reg;
   logic                  wr_hit;
   logic                  wr_first;
   logic [ADDR_W-1:0]     wr_addr;
   logic [SWM_DATA_W-1:0] wr_en;
   logic [SWM_BMASK_W-1:0] bmask_n;
   logic [SWM_NMASK_W-1:0] nmask_n;
   logic                  rarm_reg;
   logic [ADDR_W-1:0]     rarm_addr_reg;
   logic                  ract_reg;
   logic [ADDR_W-1:0]     rbase_reg;
   logic [SWM_BEAT_W-1:0] rbeat_reg;
   logic                  push_ok;
   logic                  rd_fire;
   logic                  rd_first;
   logic [ADDR_W-1:0]     rd_addr;
   logic [SWM_DATA_W-1:0] rd_word;
   logic [SWM_DATA_W-1:0] buf_mem [0:1];
   logic                  buf_wp_reg;
   logic                  buf_rp_reg;
   logic [1:0]            buf_cnt_reg;
   logic                  buf_pop;

   // ==========================================================
   // single clock strap
   // strap pins are asynchronous board levels, so two flops first
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_t_reg <= 2'h0;
         strap_c_reg <= 2'h0;
      end else begin
         strap_t_reg <= {strap_t_reg[0], out_clk_true_pin_in};
         strap_c_reg <= {strap_c_reg[0], out_clk_comp_pin_in};
      end
   end

   // caught once after release; not alterable while running
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_wait_reg  <= SWM_BEAT_RST;
         strap_done_reg  <= 1'b0;
         single_mode_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         if (strap_wait_reg == SWM_STRAP_WAIT) begin
            strap_done_reg  <= 1'b1;
            single_mode_reg <= strap_t_reg[1] & strap_c_reg[1];
         end else begin
            strap_wait_reg <= strap_wait_reg + 2'h1;
         end
      end
   end

   assign single_clock_mode_out = single_mode_reg;

   // ==========================================================
   // port select and arbitration
   always_comb begin
      rd_take = 1'b0;
      wr_take = 1'b0;
      if (true_clk_edge_in && strap_done_reg) begin
         // a select used last true edge is ignored now
         if (!read_port_select_n_in && last_op_reg != SWM_LAST_READ && !rarm_reg) begin
            rd_take = 1'b1;
         end else if (!write_port_select_n_in && last_op_reg != SWM_LAST_WRITE
                      && !warm_reg) begin
            wr_take = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         last_op_reg <= SWM_LAST_NONE;
      end else if (true_clk_edge_in) begin
         last_op_reg <= rd_take ? SWM_LAST_READ :
                        wr_take ? SWM_LAST_WRITE : SWM_LAST_NONE;
      end
   end

   // ==========================================================
   // write burst: one beat on every edge
   assign wr_first = true_clk_edge_in && warm_reg && !wact_reg;
   assign wr_hit   = wact_reg || wr_first;
   assign wr_addr  = wr_first ? warm_addr_reg
                              : ADDR_W'(wbase_reg + ADDR_W'(wbeat_reg));
   // masks are taken fresh on every beat, never latched at the start
   assign bmask_n  = {byte_lane_mask_3_n_in, byte_lane_mask_2_n_in,
                      byte_lane_mask_1_n_in, byte_lane_mask_0_n_in};
   assign nmask_n  = {nibble_lane_mask_1_n_in, nibble_lane_mask_0_n_in};
   assign wr_en    = swm_bit_enable(bmask_n, nmask_n);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         warm_reg      <= 1'b0;
         warm_addr_reg <= '0;
      end else if (wr_take) begin
         warm_reg      <= 1'b1;
         warm_addr_reg <= addr_in;
      end else if (wr_first) begin
         warm_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wact_reg  <= 1'b0;
         wbase_reg <= '0;
         wbeat_reg <= SWM_BEAT_RST;
      end else if (wr_first) begin
         wact_reg  <= 1'b1;
         wbase_reg <= warm_addr_reg;
         wbeat_reg <= SWM_BEAT_RST + 2'h1;
      end else if (wact_reg) begin
         wbeat_reg <= wbeat_reg + 2'h1;
         if (wbeat_reg == SWM_BEAT_LAST) begin
            wact_reg <= 1'b0;
         end
      end
   end

   // masked lanes keep what is stored; all masks high writes nothing
   always_ff @(posedge ref_clk_in) begin
      if (wr_hit) begin
         mem[wr_addr] <= (mem[wr_addr] & ~wr_en) | (wr_data_in & wr_en);
      end
   end

   // ==========================================================
   // read burst into the output buffer
   // beats advance on output-clock edges, or input edges in single mode
   assign push_ok  = (buf_cnt_reg != SWM_CNT_FULL)
                     && (single_mode_reg || out_clk_edge_in);
   assign rd_first = rarm_reg && !ract_reg;
   assign rd_fire  = push_ok && (ract_reg || rd_first);
   assign rd_addr  = rd_first ? rarm_addr_reg
                              : ADDR_W'(rbase_reg + ADDR_W'(rbeat_reg));

   // same-edge write to the same word is forwarded lane by lane
   always_comb begin
      rd_word = mem[rd_addr];
      if (wr_hit && wr_addr == rd_addr) begin
         rd_word = (rd_word & ~wr_en) | (wr_data_in & wr_en);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rarm_reg      <= 1'b0;
         rarm_addr_reg <= '0;
      end else if (rd_take) begin
         rarm_reg      <= 1'b1;
         rarm_addr_reg <= addr_in;
      end else if (rd_first && rd_fire) begin
         rarm_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ract_reg  <= 1'b0;
         rbase_reg <= '0;
         rbeat_reg <= SWM_BEAT_RST;
      end else if (rd_fire) begin
         if (rd_first) begin
            ract_reg  <= 1'b1;
            rbase_reg <= rarm_addr_reg;
            rbeat_reg <= SWM_BEAT_RST + 2'h1;
         end else begin
            rbeat_reg <= rbeat_reg + 2'h1;
            if (rbeat_reg == SWM_BEAT_LAST) begin
               ract_reg <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // two-entry output buffer
   // a stalled receiver holds the burst; a read armed meanwhile waits
   assign buf_pop = rd_valid_out && rd_ready_in;

   always_ff @(posedge ref_clk_in) begin
      if (rd_fire) begin
         buf_mem[buf_wp_reg] <= rd_word;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         buf_wp_reg  <= 1'b0;
         buf_rp_reg  <= 1'b0;
         buf_cnt_reg <= 2'h0;
      end else begin
         if (rd_fire) begin
            buf_wp_reg <= ~buf_wp_reg;
         end
         if (buf_pop) begin
            buf_rp_reg <= ~buf_rp_reg;
         end
         buf_cnt_reg <= buf_cnt_reg + {1'b0, rd_fire} - {1'b0, buf_pop};
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= SWM_DATA_RST;
      end else if (rd_fire && (buf_cnt_reg == 2'h0 || (buf_cnt_reg == 2'h1 && buf_pop))) begin
         rd_data_out <= rd_word;
      end else if (buf_pop) begin
         rd_data_out <= buf_mem[~buf_rp_reg];
      end
   end

   assign rd_valid_out   = (buf_cnt_reg != 2'h0);
   assign rd_data_oe_out = rd_valid_out;

endmodule

// *** dv/swm_ctrl_model.sv ***
`timescale 1ns/1ps
module swm_ctrl_model (
   input  wire logic ref_clk_in,
   output logic      true_clk_edge_out,
   output logic      out_clk_edge_out,
   output logic      out_clk_true_pin_out,
   output logic      out_clk_comp_pin_out
);
   // ======================================
   // strap and clock pacing
   // pins high from power-on: single clock mode, never altered later
   initial begin
      true_clk_edge_out    = 1'b0;
      out_clk_edge_out     = 1'b1;
      out_clk_true_pin_out = 1'b1;
      out_clk_comp_pin_out = 1'b1;
   end
   // true and complementary rises alternate, so no two true rises in a row
   always @(negedge ref_clk_in) begin
      true_clk_edge_out <= ~true_clk_edge_out;
   end
endmodule

// *** dv/swm_sram_write_mask_sva.sv ***
`timescale 1ns/1ps
module swm_wm_sva
   import swm_pkg::*;
(
   input wire logic                  ref_clk_in,
   input wire logic                  rst_n_in,
   input wire logic                  true_clk_edge_in,
   input wire logic                  read_port_select_n_in,
   input wire logic                  write_port_select_n_in,
   input wire logic                  rd_ready_in,
   input wire logic [SWM_DATA_W-1:0] rd_data_out,
   input wire logic                  rd_data_oe_out,
   input wire logic                  rd_valid_out,
   input wire logic                  single_clock_mode_out
);
   // ======================================
   // cycles since the last read select, saturating
   logic [3:0] quiet_reg;
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         quiet_reg <= 4'h0;
      end else if (true_clk_edge_in && !read_port_select_n_in) begin
         quiet_reg <= 4'h0;
      end else if (quiet_reg != 4'hf) begin
         quiet_reg <= quiet_reg + 4'h1;
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_idle;
      single_clock_mode_out && quiet_reg == 4'hf && !rd_valid_out;
   endsequence
   sequence s_rd_take;
      s_idle ##0 (true_clk_edge_in && !read_port_select_n_in);
   endsequence
   sequence s_wr_take;
      s_idle ##0 (true_clk_edge_in && !write_port_select_n_in && read_port_select_n_in);
   endsequence
   a_oe_tracks_valid: assert property (rd_data_oe_out == rd_valid_out)
      else $error("read enable differs from valid");
   a_reset_quiet: assert property ($rose(rst_n_in) |-> !rd_data_oe_out && rd_data_out == SWM_DATA_RST)
      else $error("read outputs not idle after reset");
   a_stall_holds: assert property (rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_data_out))
      else $error("read word lost during stall");
   a_mode_sticks: assert property (single_clock_mode_out |=> single_clock_mode_out)
      else $error("clock mode changed while running");
   a_strap_wait: assert property ($rose(rst_n_in) |-> !single_clock_mode_out[*3])
      else $error("clock mode latched too early");
   a_first_word: assert property (s_rd_take |-> ##[1:3] rd_valid_out)
      else $error("read burst gave no word");
   a_deselect_idle: assert property (s_idle |=> !rd_valid_out)
      else $error("read data without a read");
   a_write_no_read: assert property (s_wr_take |=> !rd_valid_out[*3])
      else $error("write produced read data");
endmodule

bind swm_sram_write_mask swm_wm_sva u_sva (
   .ref_clk_in, .rst_n_in, .true_clk_edge_in, .read_port_select_n_in,
   .write_port_select_n_in, .rd_ready_in, .rd_data_out, .rd_data_oe_out,
   .rd_valid_out, .single_clock_mode_out
);

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
   import swm_pkg::*;
;
   logic                  ref_clk_in = 1'b0;
   logic                  rst_n_in   = 1'b0;
   logic                  true_edge, out_edge, pin_t, pin_c, rd_oe, rd_valid, single_mode;
   logic                  rps_n = 1'b1, wps_n = 1'b1, rd_ready = 1'b1;
   logic [7:0]            addr   = 8'h0;
   logic [1:0]            mask_n = 2'h3;
   logic [SWM_DATA_W-1:0] wdata  = 36'h0;
   logic [SWM_DATA_W-1:0] rd_data;
   logic [SWM_DATA_W-1:0] rd_data8, rd_data9, rd_data36;
   logic [17:0]           exp_mem [256];
   logic [35:0]           exp36 [256];
   logic [7:0]            exp8 [256];
   int                    miscompares = 0;
   int                    checks      = 0;

   always #5 ref_clk_in = ~ref_clk_in;

   swm_ctrl_model u_ctrl (.ref_clk_in, .true_clk_edge_out(true_edge), .out_clk_edge_out(out_edge),
      .out_clk_true_pin_out(pin_t), .out_clk_comp_pin_out(pin_c));
   swm_sram_write_mask dut (.ref_clk_in, .rst_n_in, .true_clk_edge_in(true_edge),
      .out_clk_edge_in(out_edge), .out_clk_true_pin_in(pin_t), .out_clk_comp_pin_in(pin_c),
      .read_port_select_n_in(rps_n), .write_port_select_n_in(wps_n), .addr_in(addr),
      .wr_data_in(wdata), .byte_lane_mask_0_n_in(mask_n[0]), .byte_lane_mask_1_n_in(mask_n[1]),
      .byte_lane_mask_2_n_in(mask_n[0]), .byte_lane_mask_3_n_in(mask_n[1]),
      .nibble_lane_mask_0_n_in(mask_n[0]), .nibble_lane_mask_1_n_in(mask_n[1]),
      .rd_ready_in(rd_ready), .rd_data_out(rd_data), .rd_data_oe_out(rd_oe),
      .rd_valid_out(rd_valid), .single_clock_mode_out(single_mode));
   // other widths share the same bus; masks 2 and 3 follow masks 0 and 1
   swm_sram_write_mask #(.CFG_WIDTH(SWM_CFG_X8)) dut_x8 (.ref_clk_in, .rst_n_in,
      .true_clk_edge_in(true_edge), .out_clk_edge_in(out_edge), .out_clk_true_pin_in(pin_t),
      .out_clk_comp_pin_in(pin_c), .read_port_select_n_in(rps_n),
      .write_port_select_n_in(wps_n), .addr_in(addr), .wr_data_in(wdata),
      .byte_lane_mask_0_n_in(mask_n[0]), .byte_lane_mask_1_n_in(mask_n[1]),
      .byte_lane_mask_2_n_in(mask_n[0]), .byte_lane_mask_3_n_in(mask_n[1]),
      .nibble_lane_mask_0_n_in(mask_n[0]), .nibble_lane_mask_1_n_in(mask_n[1]),
      .rd_ready_in(rd_ready), .rd_data_out(rd_data8), .rd_data_oe_out(),
      .rd_valid_out(), .single_clock_mode_out());
   swm_sram_write_mask #(.CFG_WIDTH(SWM_CFG_X9)) dut_x9 (.ref_clk_in, .rst_n_in,
      .true_clk_edge_in(true_edge), .out_clk_edge_in(out_edge), .out_clk_true_pin_in(pin_t),
      .out_clk_comp_pin_in(pin_c), .read_port_select_n_in(rps_n),
      .write_port_select_n_in(wps_n), .addr_in(addr), .wr_data_in(wdata),
      .byte_lane_mask_0_n_in(mask_n[0]), .byte_lane_mask_1_n_in(mask_n[1]),
      .byte_lane_mask_2_n_in(mask_n[0]), .byte_lane_mask_3_n_in(mask_n[1]),
      .nibble_lane_mask_0_n_in(mask_n[0]), .nibble_lane_mask_1_n_in(mask_n[1]),
      .rd_ready_in(rd_ready), .rd_data_out(rd_data9), .rd_data_oe_out(),
      .rd_valid_out(), .single_clock_mode_out());
   swm_sram_write_mask #(.CFG_WIDTH(SWM_CFG_X36)) dut_x36 (.ref_clk_in, .rst_n_in,
      .true_clk_edge_in(true_edge), .out_clk_edge_in(out_edge), .out_clk_true_pin_in(pin_t),
      .out_clk_comp_pin_in(pin_c), .read_port_select_n_in(rps_n),
      .write_port_select_n_in(wps_n), .addr_in(addr), .wr_data_in(wdata),
      .byte_lane_mask_0_n_in(mask_n[0]), .byte_lane_mask_1_n_in(mask_n[1]),
      .byte_lane_mask_2_n_in(mask_n[0]), .byte_lane_mask_3_n_in(mask_n[1]),
      .nibble_lane_mask_0_n_in(mask_n[0]), .nibble_lane_mask_1_n_in(mask_n[1]),
      .rd_ready_in(rd_ready), .rd_data_out(rd_data36), .rd_data_oe_out(),
      .rd_valid_out(), .single_clock_mode_out());

   // ======================================
   // shared helpers
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // next cycle is a true-clock rise
   task automatic align();
      @(posedge ref_clk_in);
      if (true_edge) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask
   // m holds two active-low lane masks per beat; again repeats the start too soon
   task automatic wr(input logic [7:0] a, input logic [71:0] d, input logic [7:0] m,
                     input logic again);
      logic [7:0] b;
      align();
      wps_n = 1'b0;
      addr  = a;
      @(negedge ref_clk_in);
      wps_n = 1'b1;
      addr  = a + 8'h40;
      @(negedge ref_clk_in);
      for (int i = 0; i < 4; i++) begin
         wps_n  = !(again && i == 0);
         wdata  = {~d[18*i +: 18], d[18*i +: 18]};
         mask_n = m[2*i +: 2];
         b      = a + 8'(i);
         if (!m[2*i]) begin
            exp_mem[b][8:0] = d[18*i +: 9];
            exp36[b][8:0]   = d[18*i +: 9];
            exp36[b][26:18] = ~d[18*i +: 9];
            exp8[b][3:0]    = d[18*i +: 4];
         end
         if (!m[2*i+1]) begin
            exp_mem[b][17:9] = d[18*i+9 +: 9];
            exp36[b][17:9]   = d[18*i+9 +: 9];
            exp36[b][35:27]  = ~d[18*i+9 +: 9];
            exp8[b][7:4]     = d[18*i+4 +: 4];
         end
         @(negedge ref_clk_in);
      end
      wps_n  = 1'b1;
      mask_n = 2'h3;
   endtask
   task automatic rd(input logic [7:0] a, input int stall);
      int n;
      int t;
      align();
      rps_n    = 1'b0;
      addr     = a;
      rd_ready = (stall == 0);
      @(negedge ref_clk_in);
      rps_n = 1'b1;
      repeat (stall) @(negedge ref_clk_in);
      rd_ready = 1'b1;
      n = 0;
      t = 0;
      while (n < 4 && t < 40) begin
         if (rd_valid === 1'b1) begin
            chk(36'(rd_data[17:0]), 36'(exp_mem[a + 8'(n)]));
            chk(rd_data36, exp36[a + 8'(n)]);
            chk(36'(rd_data8[7:0]), 36'(exp8[a + 8'(n)]));
            chk(36'(rd_data9[8:0]), 36'(exp_mem[a + 8'(n)][8:0]));
            n++;
         end
         t++;
         @(negedge ref_clk_in);
      end
      chk(36'(n), 36'h4);
   endtask

   // ======================================
   // scenarios
   task automatic t_reset_idle();
      chk({34'h0, rd_oe, rd_valid}, 36'h0);
      chk(rd_data, 36'h0);
      chk(36'(single_mode), 36'h1);
   endtask
   task automatic t_masks();
      wr(8'h10, 72'h0123456789abcdef01, 8'h00, 1'b0);
      wr(8'h10, 72'hfedcba9876543210ab, 8'he4, 1'b0);
      rd(8'h10, 0);
   endtask
   task automatic t_stall_read();
      rd(8'h10, 6);
   endtask
   task automatic t_second_start();
      wr(8'h50, 72'h13579bdf02468ace13, 8'h00, 1'b0);
      wr(8'h20, 72'h2468ace013579bdf24, 8'h00, 1'b1);
      rd(8'h50, 0);
      rd(8'h20, 0);
   endtask
   task automatic t_wrap();
      wr(8'hfe, 72'h5a5a5a5a5aa5a5a5a5, 8'h00, 1'b0);
      rd(8'hfe, 0);
   endtask

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // run is under two hundred cycles; five thousand means a hang
   initial begin
      #50000;
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      rst_n_in = 1'b1;
      repeat (8) @(negedge ref_clk_in);
      t_reset_idle();
      t_masks();
      t_stall_read();
      t_second_start();
      t_wrap();
      wrap_up();
   end
endmodule
